// ### logic/dssc_top.v
// Display scan and sync controller: sync generation, TV slave sync, status, palette.
// Assumes register port on ref_clk; external sync, dot clock and field pins are asynchronous.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`include "dssc_defs.vh"

module dssc_top #(
    parameter H_W = 11,
    parameter V_W = 11
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wr_data,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rd_data_reg,
    // External sync inputs (TV mode)
    input wire external_horizontal_sync_in_n,
    input wire external_vertical_sync_in_n,
    input wire external_dot_clock,
    // Field parity pin, two-way
    input wire field_parity_pin_in,
    output reg field_parity_pin_out_reg,
    output reg field_parity_pin_oe_reg,
    // Sync outputs
    output reg hsync_n_reg,
    output reg vsync_n_reg,
    output reg composite_sync_pin_reg,
    // Video window buffer select
    input wire window_buffer_toggle,
    output reg window_buffer_sel_reg,
    // Pixel path
    input wire [7:0] pixel_index,
    output reg [17:0] pixel_rgb_reg,
    output reg display_active_reg,
    output reg color_match_out_reg,
    // Memory refresh pacing
    output reg refresh_req_reg
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0] display_mode_reg;
    reg [7:0] display_mode_reg_two;
    reg [1:0] sys_ctrl_reg;
    reg [H_W-1:0] horizontal_cycle_reg;
    reg [H_W-1:0] horizontal_sync_width_reg;
    reg [V_W-1:0] vertical_cycle_reg;
    reg [V_W-1:0] vsync_start_position_reg;
    reg [V_W-1:0] vsync_width_reg;
    reg [V_W-1:0] vertical_display_size_reg;
    reg [H_W-1:0] equalizing_pulse_width_reg;
    reg [H_W-1:0] separation_pulse_width_reg;
    reg [17:0] color_detect_high_reg;
    reg [17:0] color_detect_low_reg;
    reg [7:0] pal_index_reg;
    reg [17:0] palette [0:255];
    reg frame_flag_reg;
    reg vblank_flag_reg;
    reg displayed_buffer_flag_reg;
    reg field_even_reg;
    reg frame_second_reg;

    wire [1:0] scan_select = display_mode_reg[`DSSC_SCAN_LSB+1:`DSSC_SCAN_LSB];
    wire [1:0] sync_source_select = display_mode_reg[`DSSC_SYNC_LSB+1:`DSSC_SYNC_LSB];
    wire field_order_invert = display_mode_reg_two[`DSSC_ORDER_BIT];
    wire display_reset_bit = sys_ctrl_reg[`DSSC_RESET_BIT];
    wire display_enable_bit = sys_ctrl_reg[`DSSC_ENABLE_BIT];
    wire tv_mode = (sync_source_select == `DSSC_SYNC_TV);
    wire switch_mode = (sync_source_select == `DSSC_SYNC_SWITCH);
    wire interlaced = scan_select[1];

    function in_range;
        input [17:0] value;
        input [17:0] low;
        input [17:0] high;
        begin
            in_range = (value >= low) && (value <= high);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for asynchronous pins
    reg [1:0] hs_sync_reg;
    reg [1:0] vs_sync_reg;
    reg [1:0] dot_sync_reg;
    reg [1:0] fld_sync_reg;
    reg hs_prev_reg;
    reg vs_prev_reg;
    reg dot_prev_reg;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hs_sync_reg <= 2'h3;
            vs_sync_reg <= 2'h3;
            dot_sync_reg <= 2'h0;
            fld_sync_reg <= 2'h0;
            hs_prev_reg <= 1'b1;
            vs_prev_reg <= 1'b1;
            dot_prev_reg <= 1'b0;
        end else begin
            hs_sync_reg <= {hs_sync_reg[0], external_horizontal_sync_in_n};
            vs_sync_reg <= {vs_sync_reg[0], external_vertical_sync_in_n};
            dot_sync_reg <= {dot_sync_reg[0], external_dot_clock};
            fld_sync_reg <= {fld_sync_reg[0], field_parity_pin_in};
            hs_prev_reg <= hs_sync_reg[1];
            vs_prev_reg <= vs_sync_reg[1];
            dot_prev_reg <= dot_sync_reg[1];
        end
    end

    // Falling hsync starts a line, rising vsync starts a screen
    wire ext_line_start = tv_mode && hs_prev_reg && !hs_sync_reg[1];
    wire ext_screen_start = tv_mode && !vs_prev_reg && vs_sync_reg[1];
    // Master mode counts one dot per ref_clk; TV mode counts external dot edges
    wire dot_tick = tv_mode ? (dot_sync_reg[1] && !dot_prev_reg) : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Scan counters
    reg [H_W-1:0] h_cnt_reg;
    reg [V_W-1:0] v_cnt_reg;
    reg line_start;
    reg screen_start;
    reg [H_W-1:0] h_cnt_next;
    reg [V_W-1:0] v_cnt_next;
    wire count_hold = switch_mode || display_reset_bit;

    always @* begin
        h_cnt_next = h_cnt_reg;
        v_cnt_next = v_cnt_reg;
        line_start = 1'b0;
        screen_start = 1'b0;
        if (tv_mode) begin
            if (ext_line_start) begin
                h_cnt_next = {H_W{1'b0}};
                line_start = 1'b1;
            end else if (dot_tick && h_cnt_reg != horizontal_cycle_reg - 1'b1) begin
                h_cnt_next = h_cnt_reg + 1'b1;
            end
            // Without the sync edge the counters park at their cycle register minus one
            if (ext_screen_start) begin
                v_cnt_next = {V_W{1'b0}};
                screen_start = 1'b1;
            end else if (ext_line_start && v_cnt_reg != vertical_cycle_reg - 1'b1) begin
                v_cnt_next = v_cnt_reg + 1'b1;
            end
        end else begin
            if (h_cnt_reg >= horizontal_cycle_reg - 1'b1) begin
                h_cnt_next = {H_W{1'b0}};
                line_start = 1'b1;
                if (v_cnt_reg >= vertical_cycle_reg - 1'b1) begin
                    v_cnt_next = {V_W{1'b0}};
                    screen_start = 1'b1;
                end else begin
                    v_cnt_next = v_cnt_reg + 1'b1;
                end
            end else begin
                h_cnt_next = h_cnt_reg + 1'b1;
            end
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            h_cnt_reg <= {H_W{1'b0}};
            v_cnt_reg <= {V_W{1'b0}};
        end else if (count_hold) begin
            h_cnt_reg <= h_cnt_next;  // Line timing runs on so refresh stays paced
            v_cnt_reg <= {V_W{1'b0}};
        end else begin
            h_cnt_reg <= h_cnt_next;
            v_cnt_reg <= v_cnt_next;
        end
    end

    wire run = !count_hold;
    wire vsync_start_hit = run && line_start && (v_cnt_next == vsync_start_position_reg);
    // Frame boundary: every field except the first field of a plain interlace pair
    wire new_frame = vsync_start_hit &&
        !(scan_select == `DSSC_SCAN_INTERLACE && !frame_second_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Field, frame, buffer and status flags
    wire status_wr = reg_wr && (reg_addr == `DSSC_ADDR_STATUS);
    wire next_field_even = tv_mode ? (fld_sync_reg[1] ^ field_order_invert) :
        ~field_even_reg;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_flag_reg <= 1'b0;
            vblank_flag_reg <= 1'b0;
            displayed_buffer_flag_reg <= 1'b0;
            field_even_reg <= 1'b0;
            frame_second_reg <= 1'b0;
            window_buffer_sel_reg <= 1'b0;
        end else begin
            // Write one to clear; a flag set in the same cycle stays set
            if (new_frame) begin
                frame_flag_reg <= 1'b1;
            end else if (status_wr && reg_wr_data[`DSSC_FRAME_BIT]) begin
                frame_flag_reg <= 1'b0;
            end
            if (vsync_start_hit) begin
                vblank_flag_reg <= 1'b1;
            end else if (status_wr && reg_wr_data[`DSSC_VBLANK_BIT]) begin
                vblank_flag_reg <= 1'b0;
            end
            if (switch_mode) begin
                displayed_buffer_flag_reg <= 1'b0;
                window_buffer_sel_reg <= 1'b0;
                field_even_reg <= field_order_invert;
                frame_second_reg <= 1'b0;
            end else if (vsync_start_hit) begin
                if (!interlaced) begin
                    field_even_reg <= 1'b0;
                    frame_second_reg <= 1'b0;
                end else begin
                    field_even_reg <= next_field_even;
                    frame_second_reg <= ~frame_second_reg;
                end
                // Per-field sample in modes 00 and 11, per-frame in mode 10
                if (new_frame) begin
                    window_buffer_sel_reg <= window_buffer_toggle;
                    if (display_enable_bit) begin
                        displayed_buffer_flag_reg <= ~displayed_buffer_flag_reg;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync and composite sync generation
    wire [V_W-1:0] vs_end = vsync_start_position_reg + vsync_width_reg;
    wire in_vsync = (v_cnt_reg >= vsync_start_position_reg) && (v_cnt_reg < vs_end);
    wire in_eq = (v_cnt_reg + `DSSC_EQ_LINES >= vsync_start_position_reg && !in_vsync &&
        v_cnt_reg < vs_end + `DSSC_EQ_LINES);
    wire [H_W-1:0] half_line = {1'b0, horizontal_cycle_reg[H_W-1:1]};
    wire second_half = (h_cnt_reg >= half_line);
    wire [H_W-1:0] h_in_half = second_half ? h_cnt_reg - half_line : h_cnt_reg;
    wire [V_W-1:0] disp_lines = (scan_select == `DSSC_SCAN_SYNC_VIDEO) ?
        {1'b0, vertical_display_size_reg[V_W-1:1]} : vertical_display_size_reg;
    wire [H_W-1:0] h_active_start = horizontal_sync_width_reg;
    wire active_now = run && display_enable_bit && (v_cnt_reg < disp_lines) &&
        (h_cnt_reg >= h_active_start);

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hsync_n_reg <= 1'b1;
            vsync_n_reg <= 1'b1;
            composite_sync_pin_reg <= 1'b1;
            refresh_req_reg <= 1'b0;
            display_active_reg <= 1'b0;
            field_parity_pin_out_reg <= 1'b0;
            field_parity_pin_oe_reg <= 1'b0;
        end else begin
            hsync_n_reg <= tv_mode ? hs_sync_reg[1] : !(run && h_cnt_reg < horizontal_sync_width_reg);
            vsync_n_reg <= tv_mode ? vs_sync_reg[1] : !(run && in_vsync);
            if (tv_mode || !run) begin
                composite_sync_pin_reg <= 1'b1;
            end else if (in_vsync) begin
                composite_sync_pin_reg <= !(h_in_half < half_line - separation_pulse_width_reg);
            end else if (in_eq) begin
                composite_sync_pin_reg <= !(h_in_half < equalizing_pulse_width_reg);
            end else begin
                composite_sync_pin_reg <= !(h_cnt_reg < horizontal_sync_width_reg);
            end
            // Refresh keeps going in switch mode so memory contents survive
            refresh_req_reg <= tv_mode ? ext_line_start : (h_cnt_reg == {H_W{1'b0}});
            display_active_reg <= active_now;
            field_parity_pin_oe_reg <= (sync_source_select == `DSSC_SYNC_MASTER) && interlaced;
            field_parity_pin_out_reg <= field_even_reg ^ field_order_invert;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Palette expansion and colour match
    wire [17:0] pal_color = palette[pixel_index];

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pixel_rgb_reg <= 18'h00000;
            color_match_out_reg <= 1'b0;
        end else begin
            pixel_rgb_reg <= active_now ? pal_color : 18'h00000;
            color_match_out_reg <= tv_mode && active_now &&
                in_range(pal_color, color_detect_low_reg, color_detect_high_reg);
        end
    end

    always @(posedge ref_clk) begin
        if (reg_wr && reg_addr == `DSSC_ADDR_PAL_DATA) begin
            palette[pal_index_reg] <= reg_wr_data[17:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            display_mode_reg <= `DSSC_RST_MODE;
            display_mode_reg_two <= `DSSC_RST_MODE_TWO;
            sys_ctrl_reg <= `DSSC_RST_SYS_CTRL;
            horizontal_cycle_reg <= `DSSC_RST_H_CYCLE;
            horizontal_sync_width_reg <= `DSSC_RST_H_SYNC_WIDTH;
            vertical_cycle_reg <= `DSSC_RST_V_CYCLE;
            vsync_start_position_reg <= `DSSC_RST_V_SYNC_START;
            vsync_width_reg <= `DSSC_RST_V_SYNC_WIDTH;
            vertical_display_size_reg <= `DSSC_RST_V_DISP_SIZE;
            equalizing_pulse_width_reg <= `DSSC_RST_EQ_WIDTH;
            separation_pulse_width_reg <= `DSSC_RST_SEP_WIDTH;
            color_detect_high_reg <= 18'h00000;
            color_detect_low_reg <= 18'h00000;
            pal_index_reg <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == `DSSC_ADDR_MODE) begin
                display_mode_reg <= reg_wr_data[7:0];
            end else if (reg_addr == `DSSC_ADDR_MODE_TWO) begin
                display_mode_reg_two <= reg_wr_data[7:0];
            end else if (reg_addr == `DSSC_ADDR_SYS_CTRL) begin
                sys_ctrl_reg <= reg_wr_data[1:0];
            end else if (reg_addr == `DSSC_ADDR_H_CYCLE) begin
                horizontal_cycle_reg <= reg_wr_data[H_W-1:0];
            end else if (reg_addr == `DSSC_ADDR_H_SYNC_WIDTH) begin
                horizontal_sync_width_reg <= reg_wr_data[H_W-1:0];
            end else if (reg_addr == `DSSC_ADDR_V_CYCLE) begin
                vertical_cycle_reg <= reg_wr_data[V_W-1:0];
            end else if (reg_addr == `DSSC_ADDR_V_SYNC_START) begin
                vsync_start_position_reg <= reg_wr_data[V_W-1:0];
            end else if (reg_addr == `DSSC_ADDR_V_SYNC_WIDTH) begin
                vsync_width_reg <= reg_wr_data[V_W-1:0];
            end else if (reg_addr == `DSSC_ADDR_V_DISP_SIZE) begin
                vertical_display_size_reg <= reg_wr_data[V_W-1:0];
            end else if (reg_addr == `DSSC_ADDR_EQ_WIDTH) begin
                equalizing_pulse_width_reg <= reg_wr_data[H_W-1:0];
            end else if (reg_addr == `DSSC_ADDR_SEP_WIDTH) begin
                separation_pulse_width_reg <= reg_wr_data[H_W-1:0];
            end else if (reg_addr == `DSSC_ADDR_COLOR_HIGH) begin
                color_detect_high_reg <= reg_wr_data[17:0];
            end else if (reg_addr == `DSSC_ADDR_COLOR_LOW) begin
                color_detect_low_reg <= reg_wr_data[17:0];
            end else if (reg_addr == `DSSC_ADDR_PAL_INDEX) begin
                pal_index_reg <= reg_wr_data[7:0];
            end else if (reg_addr == `DSSC_ADDR_PAL_DATA) begin
                // Auto-increment lets software stream the whole palette
                pal_index_reg <= pal_index_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads: data valid only in the cycle after the strobe
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rd_data_reg <= 32'h00000000;
        end else if (!reg_rd) begin
            reg_rd_data_reg <= 32'h00000000;
        end else if (reg_addr == `DSSC_ADDR_MODE) begin
            reg_rd_data_reg <= {24'h000000, display_mode_reg};
        end else if (reg_addr == `DSSC_ADDR_MODE_TWO) begin
            reg_rd_data_reg <= {24'h000000, display_mode_reg_two};
        end else if (reg_addr == `DSSC_ADDR_SYS_CTRL) begin
            reg_rd_data_reg <= {30'h00000000, sys_ctrl_reg};
        end else if (reg_addr == `DSSC_ADDR_STATUS) begin
            reg_rd_data_reg <= {27'h0000000, window_buffer_sel_reg, field_even_reg,
                displayed_buffer_flag_reg, vblank_flag_reg, frame_flag_reg};
        end else if (reg_addr == `DSSC_ADDR_H_CYCLE) begin
            reg_rd_data_reg <= {{(32-H_W){1'b0}}, horizontal_cycle_reg};
        end else if (reg_addr == `DSSC_ADDR_H_SYNC_WIDTH) begin
            reg_rd_data_reg <= {{(32-H_W){1'b0}}, horizontal_sync_width_reg};
        end else if (reg_addr == `DSSC_ADDR_V_CYCLE) begin
            reg_rd_data_reg <= {{(32-V_W){1'b0}}, vertical_cycle_reg};
        end else if (reg_addr == `DSSC_ADDR_V_SYNC_START) begin
            reg_rd_data_reg <= {{(32-V_W){1'b0}}, vsync_start_position_reg};
        end else if (reg_addr == `DSSC_ADDR_V_SYNC_WIDTH) begin
            reg_rd_data_reg <= {{(32-V_W){1'b0}}, vsync_width_reg};
        end else if (reg_addr == `DSSC_ADDR_V_DISP_SIZE) begin
            reg_rd_data_reg <= {{(32-V_W){1'b0}}, vertical_display_size_reg};
        end else if (reg_addr == `DSSC_ADDR_EQ_WIDTH) begin
            reg_rd_data_reg <= {{(32-H_W){1'b0}}, equalizing_pulse_width_reg};
        end else if (reg_addr == `DSSC_ADDR_SEP_WIDTH) begin
            reg_rd_data_reg <= {{(32-H_W){1'b0}}, separation_pulse_width_reg};
        end else if (reg_addr == `DSSC_ADDR_COLOR_HIGH) begin
            reg_rd_data_reg <= {14'h0000, color_detect_high_reg};
        end else if (reg_addr == `DSSC_ADDR_COLOR_LOW) begin
            reg_rd_data_reg <= {14'h0000, color_detect_low_reg};
        end else if (reg_addr == `DSSC_ADDR_PAL_INDEX) begin
            reg_rd_data_reg <= {24'h000000, pal_index_reg};
        end else if (reg_addr == `DSSC_ADDR_PAL_DATA) begin
            reg_rd_data_reg <= {14'h0000, palette[pal_index_reg]};
        end else begin
            reg_rd_data_reg <= 32'h00000000;
        end
    end

endmodule

// ### logic/dssc_defs.vh
// Constants for the display scan and synchronization controller.
// Assumes a single ref_clk domain; every offset is a byte address on the plain register port.
`ifndef DSSC_DEFS_VH
`define DSSC_DEFS_VH

// Register byte offsets
`define DSSC_ADDR_MODE 8'h00
`define DSSC_ADDR_MODE_TWO 8'h04
`define DSSC_ADDR_SYS_CTRL 8'h08
`define DSSC_ADDR_STATUS 8'h0C
`define DSSC_ADDR_H_CYCLE 8'h10
`define DSSC_ADDR_H_SYNC_WIDTH 8'h14
`define DSSC_ADDR_V_CYCLE 8'h18
`define DSSC_ADDR_V_SYNC_START 8'h1C
`define DSSC_ADDR_V_SYNC_WIDTH 8'h20
`define DSSC_ADDR_V_DISP_SIZE 8'h24
`define DSSC_ADDR_EQ_WIDTH 8'h28
`define DSSC_ADDR_SEP_WIDTH 8'h2C
`define DSSC_ADDR_COLOR_HIGH 8'h30
`define DSSC_ADDR_COLOR_LOW 8'h34
`define DSSC_ADDR_PAL_INDEX 8'h38
`define DSSC_ADDR_PAL_DATA 8'h3C

// Mode register fields
`define DSSC_SCAN_LSB 0
`define DSSC_SYNC_LSB 2
`define DSSC_BACKGROUND_BIT 4
// Mode two register fields
`define DSSC_WINDOW_EN_BIT 0
`define DSSC_CURSOR_ONE_BIT 1
`define DSSC_CURSOR_TWO_BIT 2
`define DSSC_ORDER_BIT 3
`define DSSC_FOREGROUND_BIT 4
// System control fields
`define DSSC_RESET_BIT 0
`define DSSC_ENABLE_BIT 1
// Status fields
`define DSSC_FRAME_BIT 0
`define DSSC_VBLANK_BIT 1
`define DSSC_BUFFER_BIT 2
`define DSSC_EVEN_BIT 3
`define DSSC_WINDOW_SEL_BIT 4

// Scan and sync encodings
`define DSSC_SCAN_PROG 2'h0
`define DSSC_SCAN_INTERLACE 2'h2
`define DSSC_SCAN_SYNC_VIDEO 2'h3
`define DSSC_SYNC_MASTER 2'h0
`define DSSC_SYNC_SWITCH 2'h1
`define DSSC_SYNC_TV 2'h2

// Reset values
`define DSSC_RST_MODE 8'h00
`define DSSC_RST_MODE_TWO 8'h10
`define DSSC_RST_SYS_CTRL 2'h1
`define DSSC_RST_H_CYCLE 11'h320
`define DSSC_RST_H_SYNC_WIDTH 11'h060
`define DSSC_RST_V_CYCLE 11'h20D
`define DSSC_RST_V_SYNC_START 11'h1EA
`define DSSC_RST_V_SYNC_WIDTH 11'h002
`define DSSC_RST_V_DISP_SIZE 11'h1E0
`define DSSC_RST_EQ_WIDTH 11'h010
`define DSSC_RST_SEP_WIDTH 11'h040

// Equalizing lines before and after the vertical sync
`define DSSC_EQ_LINES 11'h003

`endif

// ### verif/dssc_sync_gen.sv
// External TV sync source: dot clock, hsync, vsync and field pin.
// Assumes run is raised just before the block is set for TV sync.
module dssc_sync_gen (
    // Control
    input wire run,
    // External sync pins
    output logic hs_n,
    output logic vs_n,
    output logic dclk,
    output logic field
);
    timeunit 1ns / 1ns;
    int dot = 0, line = 0;
    initial {hs_n, vs_n, dclk, field} = 4'hD;
    // Dot clock stands still until run; edges land after sampling
    always begin
        wait (run);
        #32 dclk <= ~dclk;
    end
    // No equalizing pulses: 30-dot lines, 12-line screens
    always @(posedge dclk) begin
        dot = (dot + 1) % 30;
        if (dot == 0) line = (line + 1) % 12;
        hs_n <= dot >= 4;
        vs_n <= line >= 2;
        if (dot == 0 && line == 0) field <= ~field;
    end
endmodule

// ### verif/dssc_top_assertions.sv
// Port checker for the display scan and sync controller.
// Assumes one ref_clk domain; the mode copy is rebuilt from bus writes.
module dssc_chk (
    // Clock, reset, register port
    input wire ref_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wr_data,
    input wire reg_wr,
    // Pins
    input wire external_horizontal_sync_in_n,
    input wire field_parity_pin_oe_reg,
    input wire composite_sync_pin_reg,
    input wire hsync_n_reg,
    input wire [17:0] pixel_rgb_reg,
    input wire display_active_reg,
    input wire color_match_out_reg,
    input wire refresh_req_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [3:0] mode_reg;
    wire tv = mode_reg[3:2] == 2'h2;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) mode_reg <= 4'h0;
        else if (reg_wr && reg_addr == 8'h00) mode_reg <= reg_wr_data[3:0];
    end
    chk_csync_tv: assert property (tv && $past(tv) |-> composite_sync_pin_reg)
        else $error("composite sync low in TV mode");
    chk_pin_in_tv: assert property (tv && $past(tv) |-> !field_parity_pin_oe_reg)
        else $error("field pin driven in TV mode");
    chk_pin_out_master: assert property (mode_reg == $past(mode_reg) |->
        field_parity_pin_oe_reg == (mode_reg[3:2] == 2'h0 && mode_reg[1]))
        else $error("field pin enable wrong for mode");
    chk_hs_echo: assert property (tv && $fell(external_horizontal_sync_in_n) |->
        ##[1:4] !hsync_n_reg) else $error("hsync does not follow external hsync");
    chk_rfr_tv: assert property (tv && $fell(external_horizontal_sync_in_n) |->
        ##[2:6] refresh_req_reg) else $error("no refresh after external hsync");
    chk_rfr_pulse: assert property (refresh_req_reg |=> !refresh_req_reg)
        else $error("refresh request longer than one cycle");
    chk_match_tv: assert property (color_match_out_reg |->
        display_active_reg && $past(tv)) else $error("colour match outside TV display");
    chk_rgb_blank: assert property (!display_active_reg |-> pixel_rgb_reg == 18'h0)
        else $error("pixel data outside display window");
endmodule
bind dssc_top dssc_chk i_chk (.*);

// ### verif/dssc_top_test.sv
// Self-checking bench: reset values, palette, master timing, TV slave mode.
// Assumes the checker is bound to dssc_top and the sync model drives the external pins.
module dssc_top_test;
    timeunit 1ns / 100ps;
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, run = 0, pend = 0, hs_d = 1, cm_seen = 0;
    logic f0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wr_data = 32'h0, seed = 32'h0C2B2572, hc = 32'h0, m;
    logic [31:0] qx[$], qm[$], qp[$];
    logic [17:0] pal[4];
    logic [7:0] wa[17] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h00, 8'h08, 8'h04,
        8'h00, 8'h08, 8'h00, 8'h30, 8'h34, 8'h1C, 8'h00, 8'h08};
    int wd[17] = '{40, 6, 20, 12, 2, 10, 2, 2, 0, 2, 1, 6, 18'h3FFFF, 0, 5, 10, 2};
    logic [7:0] ra[6] = '{8'h04, 8'h08, 8'h10, 8'h18, 8'h1C, 8'h40};
    int rx[6] = '{16, 1, 800, 525, 490, 0};
    int err_total = 0, samples_checked = 0;
    wire [31:0] rd_data;
    wire [17:0] rgb;
    wire hs_n, vs_n, dclk, fld, fp_out, fp_oe, hsync_n, vsync_n, csync, wsel, act, cm, rfr;
    always #2.5 ref_clk = ~ref_clk;
    dssc_sync_gen i_gen (.run(run), .hs_n(hs_n), .vs_n(vs_n), .dclk(dclk), .field(fld));
    dssc_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .reg_rd_data_reg(rd_data),
        .external_horizontal_sync_in_n(hs_n), .external_vertical_sync_in_n(vs_n),
        .external_dot_clock(dclk), .field_parity_pin_in(fp_oe ? fp_out : fld),
        .field_parity_pin_out_reg(fp_out), .field_parity_pin_oe_reg(fp_oe),
        .hsync_n_reg(hsync_n), .vsync_n_reg(vsync_n), .composite_sync_pin_reg(csync),
        .window_buffer_toggle(seed[3]), .window_buffer_sel_reg(wsel),
        .pixel_rgb_reg(rgb), .display_active_reg(act), .color_match_out_reg(cm),
        .pixel_index({6'h00, seed[1:0]}), .refresh_req_reg(rfr));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic cmp(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Write when w is set, else read and note the expected word under mask mk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, mk);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        if (w) reg_wr <= 1'b1;
        else begin
            reg_rd <= 1'b1;
            qx.push_back(d);
            qm.push_back(mk);
        end
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'h0;
    endtask
    // Sample a few cycles past a vsync fall so the flag update has landed
    task automatic fw(input int n);
        repeat (n) @(negedge vsync_n);
        repeat (4) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        seed <= xs(seed);
        hs_d <= hsync_n;
        hc <= (hs_d && !hsync_n) ? 32'h1 : hc + 32'h1;
        if (hs_d && !hsync_n && qp.size() > 0) cmp(hc, qp.pop_front());
        if (cm) cm_seen <= 1'b1;
        pend <= reg_rd;
        if (pend) begin
            m = qm.pop_front();
            cmp(rd_data & m, qx.pop_front() & m);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (ra[i]) acc(0, ra[i], rx[i], 32'hFFFFFFFF);
        acc(1, 8'h38, 0, 0);
        foreach (pal[i]) begin
            pal[i] = seed[17:0];
            acc(1, 8'h3C, pal[i], 0);
        end
        foreach (pal[i]) begin
            acc(1, 8'h38, i, 0);
            acc(0, 8'h3C, pal[i], 32'h3FFFF);
        end
        for (int i = 0; i < 8; i++) acc(1, wa[i], wd[i], 0);
        fw(1);
        repeat (3) qp.push_back(40);
        f0 = fp_out;
        acc(1, 8'h0C, 3, 0);
        acc(0, 8'h0C, 0, 3);
        fw(1);
        cmp(fp_out, !f0);
        fw(1);
        acc(0, 8'h0C, 3, 3);
        for (int i = 8; i < 12; i++) acc(1, wa[i], wd[i], 0);
        acc(0, 8'h0C, 0, 32'h14);
        cmp(wsel, 1'b0);
        run <= 1'b1;
        for (int i = 12; i < 17; i++) acc(1, wa[i], wd[i], 0);
        repeat (12000) @(posedge ref_clk);
        acc(1, 8'h0C, 3, 0);
        fw(3);
        acc(0, 8'h0C, 3, 3);
        cmp(cm_seen, 1'b1);
        cmp(csync, 1'b1);
        repeat (2) @(posedge ref_clk);
        test_done();
    end
    initial begin
        #400us;
        err_total++;
        test_done();
    end
endmodule
